// ---- common/timer_regs_pkg.sv ----
// constants, register map and types for the timer compare/flag block
package timer_regs_pkg;

    // ****************************************
    // register offsets on the 6-bit i/o bus
    // ****************************************
    localparam logic [5:0] ADDR_DEAD_TIME = 6'h24;
    localparam logic [5:0] ADDR_HIGH_BYTE = 6'h25;
    localparam logic [5:0] ADDR_CMP_B     = 6'h2B;
    localparam logic [5:0] ADDR_TOP       = 6'h2D;
    localparam logic [5:0] ADDR_CMP_D     = 6'h2E;
    localparam logic [5:0] ADDR_FLAGS     = 6'h38;
    localparam logic [5:0] ADDR_MASK      = 6'h39;

    // ****************************************
    // field positions
    // ****************************************
    localparam int BIT_CMP_D = 7;
    localparam int BIT_CMP_A = 6;
    localparam int BIT_CMP_B = 5;
    localparam int BIT_OVF   = 2;
    localparam logic [7:0] FLAG_BITS = 8'hE4;
    localparam int DT_TRUE_LSB = 4;
    localparam int DT_INV_LSB  = 0;
    localparam int DT_WIDTH    = 4;
    localparam int HIGH_WIDTH  = 2;

    // ****************************************
    // reset values and limits
    // ****************************************
    localparam logic [7:0] DEAD_TIME_RST = 8'h00;
    localparam logic [7:0] MASK_RST      = 8'h00;
    localparam logic [7:0] FLAGS_RST     = 8'h00;
    localparam logic [9:0] CMP_RST       = 10'h000;
    localparam logic [9:0] TOP_RST       = 10'h0FF;
    localparam logic [9:0] TOP_MIN       = 10'h003;
    localparam logic [1:0] HIGH_RST      = 2'h0;

    // ****************************************
    // interrupt vectors
    // ****************************************
    localparam logic [4:0] VEC_CMP_A = 5'h03;
    localparam logic [4:0] VEC_OVF   = 5'h04;
    localparam logic [4:0] VEC_CMP_B = 5'h09;
    localparam logic [4:0] VEC_CMP_D = 5'h10;
    localparam logic [4:0] VEC_NONE  = 5'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int SYNC_NS       = 40;
    localparam int SYNC_CYCLES   = (SYNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // dead-time edge delay states, gray along low -> wait -> high
    typedef enum logic [1:0] {
        DT_LOW  = 2'b00,
        DT_WAIT = 2'b01,
        DT_HIGH = 2'b11
    } dt_state_t;

endpackage : timer_regs_pkg

// ---- core/edge_delay.sv ----
// rising-edge delay of one output level, counted in prescaled ticks
`timescale 1ns/100ps
`default_nettype none
module edge_delay (
    // clock, reset, enable
    input  wire logic                                clk,
    input  wire logic                                rst,
    input  wire logic                                ce,
    // prescaled timer tick
    input  wire logic                                presc_tick,
    // level and delay
    input  wire logic                                level_in,
    input  wire logic [timer_regs_pkg::DT_WIDTH-1:0] delay,
    output logic                                     level_out
);
    import timer_regs_pkg::*;

    dt_state_t             state;
    dt_state_t             next_state;
    logic [DT_WIDTH-1:0]   count;
    logic [DT_WIDTH-1:0]   next_count;
    logic                  next_level_out;

    // falling edges pass at once, rising edges wait delay ticks
    always_comb
    begin
        next_state = state;
        next_count = count;
        if (ce)
        begin
            case (state)
                DT_LOW:
                begin
                    if (level_in && delay == '0)
                        next_state = DT_HIGH;
                    else if (level_in)
                    begin
                        next_state = DT_WAIT;
                        next_count = delay;
                    end
                end
                DT_WAIT:
                begin
                    if (!level_in)
                        next_state = DT_LOW;
                    else if (presc_tick && count == DT_WIDTH'(1))
                        next_state = DT_HIGH;
                    else if (presc_tick)
                        next_count = count - DT_WIDTH'(1);
                end
                DT_HIGH:
                begin
                    if (!level_in)
                        next_state = DT_LOW;
                end
                default:
                begin
                    next_state = DT_LOW;
                end
            endcase
        end
        next_level_out = (next_state == DT_HIGH);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state     <= DT_LOW;
            count     <= '0;
            level_out <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            count     <= next_count;
            level_out <= next_level_out;
        end
    end

endmodule : edge_delay
`default_nettype wire

// ---- core/event_sync.sv ----
// fixed one-stage synchronisation delay for event and clear pulses
`timescale 1ns/100ps
`default_nettype none
module event_sync #(
    parameter int WIDTH = 8
) (
    // clock, reset, enable
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // pulses
    input  wire logic [WIDTH-1:0] pulse_in,
    output logic      [WIDTH-1:0] pulse_out
);
    import timer_regs_pkg::*;

    logic [WIDTH-1:0] next_pulse_out;

    // capture only on enabled edges so a frozen block loses nothing
    always_comb
    begin
        next_pulse_out = pulse_out;
        if (ce)
        begin
            next_pulse_out = pulse_in;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pulse_out <= '0;
        end
        else
        begin
            pulse_out <= next_pulse_out;
        end
    end

endmodule : event_sync
`default_nettype wire

// ---- core/timer_compare_flags.sv ----
// compare registers, interrupt flags, mask and dead-time for the 10-bit timer
// Operation
// - channel B matches only when the counter counts onto compare_b_value
// - a bus write making counter and compare_b_value equal gives no match
// - channel B match sets compare_b_flag after a sync delay
// - counter equal to top_compare_value clears the counter in every mode
// - writes below three to top_compare_value store three
// - channel D matches only when the counter counts onto compare_d_value
// - a bus write making counter and compare_d_value equal gives no match
// - channel D match sets compare_d_flag after a sync delay
// - mask bits: D enable 7, A enable 6, B enable 5, overflow 2
// - vectors: D 0x10, A 0x03, B 0x09, overflow 0x04
// - compare_a_flag and compare_b_flag set on their matches
// - a flag clears when its interrupt vector is executed
// - software writes one to clear a flag, applied one cycle later
// - compare interrupt needs global enable, channel enable and flag
// - normal and single-slope modes set overflow at top reload
// - dual-slope mode sets overflow when counter reaches bottom
// - overflow flag clears on vector or one cycle after write-one
// - overflow interrupt needs global enable, overflow enable and flag
// - dead-time: bits 7:4 true output rise, bits 3:0 inverted rise
// - each dead-time field counts 0 to 15 prescaled ticks
// - one shared high byte serves every 10-bit register access
`timescale 1ns/100ps
`default_nettype none
module timer_compare_flags (
    // clock, reset, enable
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // cpu i/o bus
    input  wire logic [5:0] io_addr,
    input  wire logic [7:0] io_wdata,
    input  wire logic       io_we,
    input  wire logic       io_re,
    output logic      [7:0] io_rdata,
    // counter core
    input  wire logic [9:0] counter_value,
    input  wire logic       cnt_step,
    input  wire logic       cnt_down,
    input  wire logic [9:0] compare_a_value,
    input  wire logic       pwm_enable,
    input  wire logic [1:0] wave_mode,
    output logic            counter_clear,
    output logic      [1:0] shared_high_byte,
    output logic      [9:0] compare_b_value,
    output logic      [9:0] top_compare_value,
    output logic      [9:0] compare_d_value,
    // processor interrupt
    input  wire logic       global_int_en,
    input  wire logic       int_ack,
    output logic            irq_req,
    output logic      [4:0] irq_vector,
    // dead-time stage, index 0 A, 1 B, 2 D
    input  wire logic       presc_tick,
    input  wire logic [2:0] wave_level,
    output logic      [2:0] out_true,
    output logic      [2:0] out_inv
);
    import timer_regs_pkg::*;

    // ****************************************
    // helpers
    // ****************************************

    // the three 10-bit compare registers that go through the shared byte
    function automatic logic is_wide(input logic [5:0] a);
        is_wide = (a == ADDR_CMP_B) || (a == ADDR_TOP) || (a == ADDR_CMP_D);
    endfunction : is_wide

    // a match only counts on a counting step, never on a bus write
    function automatic logic count_hit(input logic step, input logic [9:0] cnt,
                                       input logic [9:0] cmp);
        count_hit = step && (cnt == cmp);
    endfunction : count_hit

    // ****************************************
    // register file
    // ****************************************
    logic [7:0] dead_time_value;
    logic [7:0] timer_interrupt_mask;
    logic [7:0] timer_interrupt_flags;
    logic [7:0] next_dead_time;
    logic [7:0] next_mask;
    logic [1:0] next_high;
    logic [9:0] next_cmp_b;
    logic [9:0] next_top;
    logic [9:0] next_cmp_d;
    logic [7:0] next_rdata;
    logic [9:0] wide_wdata;
    logic       wr;
    logic       rd;

    assign wr = ce && io_we;
    assign rd = ce && io_re;
    assign wide_wdata = {shared_high_byte, io_wdata};

    // bus writes; a wide read parks the upper bits in the shared byte
    always_comb
    begin
        next_dead_time = dead_time_value;
        next_mask      = timer_interrupt_mask;
        next_high      = shared_high_byte;
        next_cmp_b     = compare_b_value;
        next_top       = top_compare_value;
        next_cmp_d     = compare_d_value;
        next_rdata     = io_rdata;
        if (wr)
        begin
            case (io_addr)
                ADDR_DEAD_TIME: next_dead_time = io_wdata;
                ADDR_MASK:      next_mask      = io_wdata;
                ADDR_HIGH_BYTE: next_high      = io_wdata[HIGH_WIDTH-1:0];
                ADDR_CMP_B:     next_cmp_b     = wide_wdata;
                ADDR_CMP_D:     next_cmp_d     = wide_wdata;
                ADDR_TOP:       next_top = (wide_wdata < TOP_MIN) ? TOP_MIN : wide_wdata;
                default:        next_mask      = timer_interrupt_mask;
            endcase
        end
        if (rd)
        begin
            case (io_addr)
                ADDR_DEAD_TIME: next_rdata = dead_time_value;
                ADDR_MASK:      next_rdata = timer_interrupt_mask;
                ADDR_FLAGS:     next_rdata = timer_interrupt_flags;
                ADDR_HIGH_BYTE: next_rdata = {6'h00, shared_high_byte};
                ADDR_CMP_B:     next_rdata = compare_b_value[7:0];
                ADDR_TOP:       next_rdata = top_compare_value[7:0];
                ADDR_CMP_D:     next_rdata = compare_d_value[7:0];
                default:        next_rdata = 8'h00; // unmapped reads zero
            endcase
            if (is_wide(io_addr))
            begin
                case (io_addr)
                    ADDR_CMP_B: next_high = compare_b_value[9:8];
                    ADDR_TOP:   next_high = top_compare_value[9:8];
                    default:    next_high = compare_d_value[9:8];
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dead_time_value      <= DEAD_TIME_RST;
            timer_interrupt_mask <= MASK_RST;
            shared_high_byte     <= HIGH_RST;
            compare_b_value      <= CMP_RST;
            top_compare_value    <= TOP_RST;
            compare_d_value      <= CMP_RST;
            io_rdata             <= 8'h00;
        end
        else
        begin
            dead_time_value      <= next_dead_time;
            timer_interrupt_mask <= next_mask;
            shared_high_byte     <= next_high;
            compare_b_value      <= next_cmp_b;
            top_compare_value    <= next_top;
            compare_d_value      <= next_cmp_d;
            io_rdata             <= next_rdata;
        end
    end

    // ****************************************
    // match and overflow events
    // ****************************************
    logic       match_a;
    logic       match_b;
    logic       match_d;
    logic       top_hit;
    logic       dual_slope;
    logic       ovf_evt;
    logic [7:0] sync_in;
    logic [7:0] sync_out;
    logic [7:0] wr_clear;

    assign match_a = count_hit(cnt_step, counter_value, compare_a_value);
    assign match_b = count_hit(cnt_step, counter_value, compare_b_value);
    assign match_d = count_hit(cnt_step, counter_value, compare_d_value);
    assign top_hit = count_hit(cnt_step, counter_value, top_compare_value);
    assign counter_clear = top_hit;
    // phase-and-frequency correct and dual-slope modes wrap at bottom
    assign dual_slope = pwm_enable && wave_mode[0];
    assign ovf_evt = dual_slope ? (cnt_step && cnt_down && counter_value == 10'h000)
                                : top_hit;
    assign wr_clear = (wr && io_addr == ADDR_FLAGS) ? (io_wdata & FLAG_BITS) : 8'h00;

    // compare events in the upper nibble, write-one clears in the lower
    assign sync_in = {match_d, match_a, match_b, 1'b0,
                      wr_clear[BIT_CMP_D], wr_clear[BIT_CMP_A], wr_clear[BIT_CMP_B],
                      wr_clear[BIT_OVF]};

    event_sync #(
        .WIDTH     (8)
    ) u_sync (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .pulse_in  (sync_in),
        .pulse_out (sync_out)
    );

    // ****************************************
    // flags and interrupt request
    // ****************************************
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic [7:0] ack_vec;
    logic [7:0] pending;
    logic [7:0] next_flags;

    assign set_vec = {sync_out[7], sync_out[6], sync_out[5], 2'b00, ovf_evt, 2'b00};
    assign pending = timer_interrupt_flags & timer_interrupt_mask & FLAG_BITS
                     & {8{global_int_en}};
    assign irq_req = |pending;

    // fixed priority by vector number, lowest first
    always_comb
    begin
        ack_vec    = 8'h00;
        irq_vector = VEC_NONE;
        if (pending[BIT_CMP_A])
        begin
            irq_vector = VEC_CMP_A;
            ack_vec[BIT_CMP_A] = int_ack;
        end
        else if (pending[BIT_OVF])
        begin
            irq_vector = VEC_OVF;
            ack_vec[BIT_OVF] = int_ack;
        end
        else if (pending[BIT_CMP_B])
        begin
            irq_vector = VEC_CMP_B;
            ack_vec[BIT_CMP_B] = int_ack;
        end
        else if (pending[BIT_CMP_D])
        begin
            irq_vector = VEC_CMP_D;
            ack_vec[BIT_CMP_D] = int_ack;
        end
    end

    assign clr_vec = {sync_out[3], sync_out[2], sync_out[1], 2'b00, sync_out[0], 2'b00}
                     | ack_vec;

    // set beats clear so an event in the clearing cycle survives
    always_comb
    begin
        next_flags = timer_interrupt_flags;
        if (ce)
        begin
            next_flags = ((timer_interrupt_flags & ~clr_vec) | set_vec) & FLAG_BITS;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            timer_interrupt_flags <= FLAGS_RST;
        end
        else
        begin
            timer_interrupt_flags <= next_flags;
        end
    end

    // ****************************************
    // dead-time generators, one pair per channel
    // ****************************************
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1)
        begin : g_dt
            edge_delay u_true (
                .clk        (clk),
                .rst        (rst),
                .ce         (ce),
                .presc_tick (presc_tick),
                .level_in   (wave_level[ch]),
                .delay      (dead_time_value[DT_TRUE_LSB +: DT_WIDTH]),
                .level_out  (out_true[ch])
            );
            edge_delay u_inv (
                .clk        (clk),
                .rst        (rst),
                .ce         (ce),
                .presc_tick (presc_tick),
                .level_in   (!wave_level[ch]),
                .delay      (dead_time_value[DT_INV_LSB +: DT_WIDTH]),
                .level_out  (out_inv[ch])
            );
        end
    endgenerate

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    flag_b_delay_a: assert property (ce && match_b ##1 ce |=> timer_interrupt_flags[5])
        else $error("compare b flag not set one cycle after match");
    flag_d_delay_a: assert property (ce && match_d ##1 ce |=> timer_interrupt_flags[7])
        else $error("compare d flag not set one cycle after match");
    no_step_match_a: assert property (!cnt_step |-> !match_b && !match_d)
        else $error("match without a counting step");
    top_clear_a: assert property (counter_clear == (cnt_step
                                  && counter_value == top_compare_value))
        else $error("counter clear not tied to top match");
    top_min_a: assert property (top_compare_value >= TOP_MIN)
        else $error("top compare below minimum");
    ovf_set_a: assert property (ce && ovf_evt |=> timer_interrupt_flags[2])
        else $error("overflow flag not set on overflow event");
    wr_clear_a: assert property (wr && io_addr == ADDR_FLAGS && io_wdata[7] && !match_d
                                 ##1 ce && !match_d ##0 !sync_out[7]
                                 |=> !timer_interrupt_flags[7])
        else $error("write-one clear not applied after one cycle");
    wr_zero_a: assert property (wr && io_addr == ADDR_FLAGS && !io_wdata[6]
                                && timer_interrupt_flags[6] && !ack_vec[6] && !sync_out[2]
                                ##1 !int_ack |-> timer_interrupt_flags[6])
        else $error("writing zero changed a flag");
    irq_gate_a: assert property (irq_req |-> global_int_en
                                 && |(timer_interrupt_flags & timer_interrupt_mask))
        else $error("interrupt raised without enable and flag");
    ack_clear_a: assert property (ce && int_ack && irq_vector == VEC_CMP_A && !sync_out[6]
                                  |=> !timer_interrupt_flags[6])
        else $error("vector execution did not clear flag");

    match_b_c: cover property (ce && match_b ##2 timer_interrupt_flags[5]);
    ovf_dual_c: cover property (dual_slope && ovf_evt);
    irq_ack_c: cover property (irq_req && int_ack);
    top_clamp_c: cover property (wr && io_addr == ADDR_TOP && wide_wdata < TOP_MIN);

endmodule : timer_compare_flags
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the timer compare, flag and dead-time block
`timescale 1ns/100ps
`default_nettype none
module tb;
    import timer_regs_pkg::*;
    logic       clk = 0, rst = 1, ce = 1, io_we = 0, io_re = 0, int_ack = 0;
    logic       cnt_step = 0, cnt_down = 0, pwm_enable = 0, global_int_en = 1;
    logic       presc_tick = 0, counter_clear, irq_req;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00, io_rdata;
    logic [9:0] counter_value = 10'h000, compare_a_value = 10'h3FF;
    logic [9:0] compare_b_value, top_compare_value, compare_d_value, v;
    logic [1:0] wave_mode = 2'h0, shared_high_byte;
    logic [4:0] irq_vector;
    logic [2:0] wave_level = 3'h0, out_true, out_inv;
    int         bad_count = 0, checked = 0, cycles = 0, b, m [64];
    int         bits [3] = '{BIT_CMP_B, BIT_CMP_D, BIT_CMP_A};
    logic [4:0] vecs [3] = '{VEC_CMP_B, VEC_CMP_D, VEC_CMP_A};
    logic [5:0] adrs [3] = '{ADDR_CMP_B, ADDR_CMP_D, 6'h00};
    logic [3:0] modes [5] = '{4'h0, 4'h8, 4'hB, 4'hC, 4'hF};

    timer_compare_flags dut (.clk, .rst, .ce, .io_addr, .io_wdata, .io_we, .io_re,
        .io_rdata, .counter_value, .cnt_step, .cnt_down, .compare_a_value, .pwm_enable,
        .wave_mode, .counter_clear, .shared_high_byte, .compare_b_value,
        .top_compare_value, .compare_d_value, .global_int_en, .int_ack, .irq_req,
        .irq_vector, .presc_tick, .wave_level, .out_true, .out_inv);

    // 25 MHz clock; timeout sized well past the whole sequence
    initial forever #20 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            bad_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    task automatic cmp(string what, logic [9:0] exp, logic [9:0] got);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // bus write, mirrored into the model with the top minimum applied
    task automatic wr(logic [5:0] a, logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_we = 1;
        @(negedge clk);
        io_we = 0;
        if (a inside {ADDR_CMP_B, ADDR_CMP_D, ADDR_TOP})
            m[a] = {m[ADDR_HIGH_BYTE][1:0], d};
        else if (a == ADDR_HIGH_BYTE)
            m[a] = d & 3;
        else if (a inside {ADDR_DEAD_TIME, ADDR_MASK})
            m[a] = d;
        if (a == ADDR_TOP && m[a] < 3)
            m[a] = 3;
    endtask : wr

    // bus read compared with the model; a low-byte read loads the high byte
    task automatic rd(logic [5:0] a);
        @(negedge clk);
        io_addr = a;
        io_re = 1;
        @(negedge clk);
        io_re = 0;
        cmp("read data", m[a] & 8'hFF, io_rdata);
        if (a inside {ADDR_CMP_B, ADDR_CMP_D, ADDR_TOP})
            m[ADDR_HIGH_BYTE] = m[a] >> 8;
    endtask : rd

    // one counting step onto value c, then the request is dropped
    task automatic step(logic [9:0] c);
        @(negedge clk);
        counter_value = c;
        cnt_step = 1;
        @(negedge clk);
        cnt_step = 0;
    endtask : step

    task automatic irq(logic r, logic [4:0] vec);
        cmp("irq_req", r, irq_req);
        if (r)
            cmp("irq_vector", vec, irq_vector);
    endtask : irq

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        void'($urandom(32'hC66F9167));
        foreach (m[i]) m[i] = 0;
        m[ADDR_TOP] = TOP_RST;
        repeat (8) @(negedge clk);
        rst = 0;
        foreach (adrs[i]) rd(adrs[i]);
        rd(ADDR_TOP);
        rd(ADDR_DEAD_TIME);
        rd(ADDR_MASK);
        wr(6'h3F, 8'h5A);
        rd(6'h3F);
        wr(ADDR_DEAD_TIME, $urandom);
        rd(ADDR_DEAD_TIME);
        wr(ADDR_MASK, $urandom);
        rd(ADDR_MASK);
        wr(ADDR_MASK, FLAG_BITS);
        wr(ADDR_HIGH_BYTE, 8'h00);
        wr(ADDR_TOP, 8'h01);
        rd(ADDR_TOP);
        cmp("top", 10'h003, top_compare_value);
        // compare channels: equal without a counting step gives nothing, counting onto it sets the flag
        for (int k = 0; k < 3; k++)
        begin
            b = bits[k];
            v = 10'(16 + 320 * k + $urandom % 256);
            if (k < 2)
            begin
                wr(ADDR_HIGH_BYTE, v[9:8]);
                wr(adrs[k], v[7:0]);
                cmp("compare", v, k ? compare_d_value : compare_b_value);
                rd(adrs[k]);
                rd(ADDR_HIGH_BYTE);
            end
            @(negedge clk);
            compare_a_value = (k == 2) ? v : 10'h3FF;
            counter_value = v;
            repeat (3) @(negedge clk);
            irq(0, 0);
            // match captured into the sync stage at the step edge, flag set on the next edge
            step(v);
            irq(0, 0);
            @(negedge clk);
            irq(1, vecs[k]);
            m[ADDR_FLAGS] = 1 << b;
            rd(ADDR_FLAGS);
            global_int_en = 0;
            #1 irq(0, 0);
            @(negedge clk);
            global_int_en = 1;
            int_ack = 1;
            @(negedge clk);
            int_ack = 0;
            irq(0, 0);
            step(v);
            repeat (2) @(negedge clk);
            wr(ADDR_FLAGS, 8'h00);
            irq(1, vecs[k]);
            // the clear passes the sync stage first, so the flag stands one more cycle
            wr(ADDR_FLAGS, 8'(1 << b));
            irq(1, vecs[k]);
            @(negedge clk);
            irq(0, 0);
        end
        // overflow per mode: top reload, or bottom while counting down in dual slope
        foreach (modes[i])
        begin
            @(negedge clk);
            {pwm_enable, cnt_down, wave_mode} = modes[i];
            counter_value = cnt_down ? 10'h000 : 10'h003;
            cnt_step = 1;
            // dual-slope modes overflow at bottom only, the others at top only
            b = ((pwm_enable && wave_mode[0]) == cnt_down);
            #1 cmp("counter_clear", !cnt_down, counter_clear);
            irq(0, 0);
            @(negedge clk);
            cnt_step = 0;
            irq(b, VEC_OVF);
            int_ack = 1;
            @(negedge clk);
            int_ack = 0;
            irq(0, 0);
        end
        // dead time: true edge waits three ticks, inverted edge none
        wr(ADDR_DEAD_TIME, 8'h30);
        cmp("out_inv", 3'h7, out_inv);
        @(negedge clk);
        wave_level = 3'h7;
        repeat (4) @(negedge clk);
        cmp("out_inv", 3'h0, out_inv);
        cmp("out_true", 3'h0, out_true);
        for (int t = 0; t < 3; t++)
        begin
            @(negedge clk);
            presc_tick = 1;
            @(negedge clk);
            presc_tick = 0;
            if (t == 1)
                cmp("out_true", 3'h0, out_true);
        end
        for (int w = 0; w < 3 && out_true !== 3'h7; w++) @(negedge clk);
        cmp("out_true", 3'h7, out_true);
        finish_test();
    end
endmodule : tb
`default_nettype wire
